// ==== design/bxt_pkg.sv ====
/*
  Package for the board connectivity test block: pin counts of the two
  parity chains, the packed state record and its reset value, and the
  carrier for the monitor chain pins.
  Assumes one clock and a synchronous, active-high system reset.
*/
package bxt_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Peripheral section chain sizes
  localparam int SIO_PIN_TOTAL = 100;
  localparam int SIO_PIN_EXCLUDED = 13;
  localparam int SIO_CHAIN_W = SIO_PIN_TOTAL - SIO_PIN_EXCLUDED;
  localparam int SIO_ENTRY_W = 2;
  localparam int SIO_OTHER_W = SIO_CHAIN_W - SIO_ENTRY_W;

  ////////////////////////////////////////////////////////////////////////
  // Monitor section chain sizes
  localparam int MON_VID_W = 5;
  localparam int MON_SMBUS_W = 2;
  localparam int MON_CHAIN_W = MON_VID_W + MON_SMBUS_W;

  ////////////////////////////////////////////////////////////////////////
  // Level that the monitor strap must show to enter its chain mode
  localparam logic MON_STRAP_ENTER = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Whole state of the block
  typedef struct packed {
    logic sio_mode;
    logic host_rst_n_prev;
    logic mon_mode;
    logic mon_cap_pend;
  } bxt_state_t;

  // Previous host reset starts high so power-up is no false edge
  localparam bxt_state_t BXT_STATE_RST = '{
    sio_mode: 1'b0,
    host_rst_n_prev: 1'b1,
    mon_mode: 1'b0,
    mon_cap_pend: 1'b1
  };

  ////////////////////////////////////////////////////////////////////////
  // Monitor chain pins, highest voltage-code bit first
  typedef struct packed {
    logic [MON_VID_W-1:0] processor_voltage_code;
    logic smbus_clk;
    logic smbus_data;
  } bxt_mon_pins_t;

endpackage

// ==== design/bxt_top.sv ====
/*
  Board connectivity test logic with two independent parity chains: one
  over the peripheral section pins, output on the first serial transmit
  pin, one over the monitor section pins, output on the shared
  address/reset/alert pin.
  Assumes all pin levels arrive synchronous to clk, that sys_rst is the
  main supply power-on reset, and that hw_mon_pwr_rst marks a power-up of
  the monitor section.
*/
module bxt_top #(
  parameter int SIO_OTHER_W = bxt_pkg::SIO_OTHER_W
) (
  // Clock and main power-on reset
  input logic clk,
  input logic sys_rst,
  // Host bus pins used for entry
  input logic host_rst_n,
  input logic host_frame_n,
  input logic host_ad0,
  input logic host_ad0_oe_n_norm,
  output logic host_ad0_oe_n,
  // Remaining peripheral signal pins
  input logic [SIO_OTHER_W-1:0] sio_pin_in,
  input logic [SIO_OTHER_W-1:0] sio_pin_oe_n_norm,
  output logic [SIO_OTHER_W-1:0] sio_pin_oe_n,
  // First serial port transmit pin
  input logic uart1_tx_norm,
  output logic serial_port_one_transmit,
  // Monitor section power-up and strap
  input logic hw_mon_pwr_rst,
  input logic mon_test_strap,
  // Monitor chain pins
  input bxt_pkg::bxt_mon_pins_t mon_pins,
  input logic mon_smbus_data_oe_n_norm,
  output logic mon_smbus_data_oe_n,
  // Shared address select / reset / over-limit alert pin
  input logic mon_shared_out_norm,
  input logic mon_shared_oe_n_norm,
  output logic mon_shared_out,
  output logic mon_shared_oe_n,
  // Mode indications
  output logic sio_test_active,
  output logic mon_test_active
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (SIO_OTHER_W < 1)
  begin : g_bad_width
    $error("SIO_OTHER_W must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // Chain functions

  // Even parity: all low reads low, any single change toggles
  function automatic logic sio_chain(
    input logic [SIO_OTHER_W-1:0] pins,
    input logic frame_n,
    input logic ad0
  );
    return ^{pins, frame_n, ad0};
  endfunction

  // Inverted parity: all low reads high
  function automatic logic mon_chain(
    input bxt_pkg::bxt_mon_pins_t pins
  );
    return ~^pins;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  bxt_pkg::bxt_state_t st_q;
  bxt_pkg::bxt_state_t st_d;
  logic host_rise;
  logic sio_entry_low;
  logic sio_chain_val;
  logic mon_chain_val;

  // Host reset excluded from the parity on purpose
  assign sio_chain_val = sio_chain(sio_pin_in, host_frame_n,
                                   host_ad0);
  assign mon_chain_val = mon_chain(mon_pins);

  assign host_rise = host_rst_n & ~st_q.host_rst_n_prev;
  assign sio_entry_low = ~host_frame_n & ~host_ad0;

  always_comb
  begin
    st_d = st_q;
    st_d.host_rst_n_prev = host_rst_n;
    // Flag only moves on the reset rising edge
    if (host_rise)
    begin
      st_d.sio_mode = sio_entry_low;
    end
    // Monitor strap caught on the first cycle after its power-up
    if (hw_mon_pwr_rst)
    begin
      st_d.mon_mode = 1'b0;
      st_d.mon_cap_pend = 1'b1;
    end
    else if (st_q.mon_cap_pend)
    begin
      st_d.mon_mode = (mon_test_strap == bxt_pkg::MON_STRAP_ENTER);
      st_d.mon_cap_pend = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= bxt_pkg::BXT_STATE_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Peripheral pins
  // Outputs are muxed, not registered: the chain must follow pin levels
  // without waiting for a clock edge.

  always_comb
  begin
    if (st_q.sio_mode)
    begin
      serial_port_one_transmit = sio_chain_val;
      host_ad0_oe_n = 1'b1;
    end
    else
    begin
      serial_port_one_transmit = uart1_tx_norm;
      host_ad0_oe_n = host_ad0_oe_n_norm;
    end
  end

  for (genvar i = 0; i < SIO_OTHER_W; i++)
  begin : g_sio_release
    assign sio_pin_oe_n[i] = st_q.sio_mode | sio_pin_oe_n_norm[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // Monitor pins, driven only from the monitor flag

  always_comb
  begin
    if (st_q.mon_mode)
    begin
      mon_shared_out = mon_chain_val;
      mon_shared_oe_n = 1'b0;
      mon_smbus_data_oe_n = 1'b1;
    end
    else
    begin
      mon_shared_out = mon_shared_out_norm;
      mon_shared_oe_n = mon_shared_oe_n_norm;
      mon_smbus_data_oe_n = mon_smbus_data_oe_n_norm;
    end
  end

  assign sio_test_active = st_q.sio_mode;
  assign mon_test_active = st_q.mon_mode;

  ////////////////////////////////////////////////////////////////////////
  // Checks on entry and exit of the peripheral chain

  AST_SIO_ENTER: assert property (
    @(posedge clk) disable iff (sys_rst)
    host_rise && !host_frame_n && !host_ad0 |=> sio_test_active
  ) else $error("peripheral chain not entered on reset rise");

  AST_SIO_EXIT: assert property (
    @(posedge clk) disable iff (sys_rst)
    host_rise && (host_frame_n || host_ad0) |=> !sio_test_active
  ) else $error("peripheral chain not left on reset rise");

  AST_SIO_POR: assert property (
    @(posedge clk)
    sys_rst |=> !sio_test_active && !mon_test_active
  ) else $error("power-on reset left a test mode set");

  AST_SIO_HOLD: assert property (
    @(posedge clk) disable iff (sys_rst)
    !host_rise |=> sio_test_active == $past(sio_test_active)
  ) else $error("peripheral flag moved without reset rise");

  AST_SIO_LOW_HOLD: assert property (
    @(posedge clk) disable iff (sys_rst)
    !host_rst_n ##1 !host_rst_n |-> $stable(sio_test_active)
  ) else $error("peripheral flag moved while host reset low");

  ////////////////////////////////////////////////////////////////////////
  // Checks on the peripheral chain output

  AST_SIO_CHAIN: assert property (
    @(posedge clk) disable iff (sys_rst)
    sio_test_active |-> serial_port_one_transmit ==
      ^{sio_pin_in, host_frame_n, host_ad0}
  ) else $error("transmit pin does not carry peripheral chain");

  AST_SIO_TOGGLE: assert property (
    @(posedge clk) disable iff (sys_rst)
    sio_test_active && $past(sio_test_active) &&
    $countones({sio_pin_in, host_frame_n, host_ad0} ^
      $past({sio_pin_in, host_frame_n, host_ad0})) == 1
    |-> serial_port_one_transmit != $past(serial_port_one_transmit)
  ) else $error("single input change did not toggle transmit");

  AST_SIO_ZERO: assert property (
    @(posedge clk) disable iff (sys_rst)
    sio_test_active && sio_pin_in == '0 && !host_frame_n && !host_ad0
    |-> !serial_port_one_transmit
  ) else $error("all-low peripheral inputs did not give low");

  AST_SIO_NORMAL: assert property (
    @(posedge clk) disable iff (sys_rst)
    !sio_test_active |-> serial_port_one_transmit == uart1_tx_norm
  ) else $error("transmit pin not normal outside test mode");

  AST_SIO_RELEASE: assert property (
    @(posedge clk) disable iff (sys_rst)
    sio_test_active |-> &sio_pin_oe_n && host_ad0_oe_n
  ) else $error("peripheral pin still driven in test mode");

  ////////////////////////////////////////////////////////////////////////
  // Checks on the monitor chain

  AST_MON_STRAP: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(hw_mon_pwr_rst) |=> mon_test_active == $past(mon_test_strap)
  ) else $error("monitor strap not taken at power-up");

  AST_MON_HOLD: assert property (
    @(posedge clk) disable iff (sys_rst)
    mon_test_active && !hw_mon_pwr_rst [*2] |-> mon_test_active
  ) else $error("monitor mode left without power-down");

  AST_MON_OFF: assert property (
    @(posedge clk) disable iff (sys_rst)
    hw_mon_pwr_rst |=> !mon_test_active
  ) else $error("monitor mode held through power-down");

  AST_MON_CHAIN: assert property (
    @(posedge clk) disable iff (sys_rst)
    mon_test_active |-> !mon_shared_oe_n && mon_smbus_data_oe_n &&
      mon_shared_out == ~^mon_pins
  ) else $error("shared pin does not carry monitor chain");

  AST_MON_ZERO: assert property (
    @(posedge clk) disable iff (sys_rst)
    mon_test_active && mon_pins == '0 |-> mon_shared_out
  ) else $error("all-low monitor inputs did not give high");

  AST_MON_SEPARATE: assert property (
    @(posedge clk) disable iff (sys_rst)
    !hw_mon_pwr_rst && !st_q.mon_cap_pend && host_rise
    |=> $stable(mon_test_active)
  ) else $error("host reset edge disturbed monitor mode");

  AST_MON_NORMAL: assert property (
    @(posedge clk) disable iff (sys_rst)
    !mon_test_active |-> mon_shared_out == mon_shared_out_norm &&
      mon_shared_oe_n == mon_shared_oe_n_norm
  ) else $error("shared pin not normal outside test mode");

endmodule // bxt_top

// ==== verif/bxt_tester.sv ====
/*
  Board test equipment model: holds every chain pin level and steps it.
  Assumes callers want pin changes just after the falling edge of clk.
*/
module bxt_tester (
  // Clock
  input logic clk,
  // Pin levels driven onto the board
  output logic host_rst_n,
  output logic host_frame_n,
  output logic host_ad0,
  output logic [bxt_pkg::SIO_OTHER_W-1:0] sio_pin_in,
  output logic hw_mon_pwr_rst,
  output logic mon_test_strap,
  output bxt_pkg::bxt_mon_pins_t mon_pins
);
  // Bit 1 is frame, bit 0 is ad0: entry terms that join the chain
  logic [bxt_pkg::SIO_CHAIN_W-1:0] chain = '0;
  assign sio_pin_in = chain[bxt_pkg::SIO_CHAIN_W-1:2];
  assign host_frame_n = chain[1];
  assign host_ad0 = chain[0];
  initial
  begin
    host_rst_n = 1'b1;
    hw_mon_pwr_rst = 1'b0;
    mon_test_strap = 1'b0;
    mon_pins = '0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic host_reset(input logic frame_n, input logic ad0);
    @(negedge clk);
    chain[1:0] = {frame_n, ad0};
    host_rst_n = 1'b0;
    @(negedge clk);
    host_rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chain[1:0] = 2'h0;
  endtask
  // Strap is held across the whole monitor power-up
  task automatic mon_power(input logic strap);
    @(negedge clk);
    mon_test_strap = strap;
    hw_mon_pwr_rst = 1'b1;
    @(negedge clk);
    hw_mon_pwr_rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic set_bit(input int idx, input logic v);
    @(negedge clk);
    chain[idx] = v;
  endtask
  task automatic set_mon(input logic [6:0] v);
    @(negedge clk);
    mon_pins = v;
  endtask
endmodule // bxt_tester

// ==== verif/board_xnor_chain_test_bench.sv ====
/*
  Self-checking bench for the board connectivity test block.
  Assumes the tester model drives all chain pins and strap levels.
*/
module board_xnor_chain_test_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [6:0] pins; logic out;} bxt_row_t;
  localparam int W = bxt_pkg::SIO_OTHER_W;
  localparam int CW = bxt_pkg::SIO_CHAIN_W;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic uart_norm = 1'b1;
  logic ad0_oe_norm = 1'b0;
  logic sda_oe_norm = 1'b0;
  logic sh_out_norm = 1'b1;
  logic sh_oe_norm = 1'b1;
  logic [W-1:0] oe_norm = 85'h0ff00ff;
  logic rst_n, frame_n, ad0, pwr_rst, strap, e;
  logic [W-1:0] pins, oe_n;
  bxt_pkg::bxt_mon_pins_t mon_pins;
  logic ad0_oe_n, tx, sda_oe_n, sh_out, sh_oe_n, sio_act, mon_act;
  logic [6:0] v;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  // Descending walk of the monitor chain, strict alternation
  bxt_row_t rows [8] = '{'{7'h00, 1'b1}, '{7'h40, 1'b0}, '{7'h60, 1'b1},
    '{7'h70, 1'b0}, '{7'h78, 1'b1}, '{7'h7c, 1'b0}, '{7'h7e, 1'b1},
    '{7'h7f, 1'b0}};
  always #50 clk = ~clk;
  bxt_tester tst (.clk(clk), .host_rst_n(rst_n), .host_frame_n(frame_n),
    .host_ad0(ad0), .sio_pin_in(pins), .hw_mon_pwr_rst(pwr_rst),
    .mon_test_strap(strap), .mon_pins(mon_pins));
  bxt_top DUT (.clk(clk), .sys_rst(sys_rst), .host_rst_n(rst_n),
    .host_frame_n(frame_n), .host_ad0(ad0),
    .host_ad0_oe_n_norm(ad0_oe_norm), .host_ad0_oe_n(ad0_oe_n),
    .sio_pin_in(pins), .sio_pin_oe_n_norm(oe_norm), .sio_pin_oe_n(oe_n),
    .uart1_tx_norm(uart_norm), .serial_port_one_transmit(tx),
    .hw_mon_pwr_rst(pwr_rst), .mon_test_strap(strap),
    .mon_pins(mon_pins), .mon_smbus_data_oe_n_norm(sda_oe_norm),
    .mon_smbus_data_oe_n(sda_oe_n), .mon_shared_out_norm(sh_out_norm),
    .mon_shared_oe_n_norm(sh_oe_norm), .mon_shared_out(sh_out),
    .mon_shared_oe_n(sh_oe_n), .sio_test_active(sio_act),
    .mon_test_active(mon_act));
  ////////////////////////////////////////////////////////////////
  task automatic chk1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkv(input string what, input logic [W-1:0] exp,
    input logic [W-1:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Whole run is a few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fails++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    chk1("sio_act", 1'b0, sio_act);
    chk1("tx", 1'b1, tx);
    chkv("oe_n", oe_norm, oe_n);
    tst.mon_power(1'b1);
    chk1("mon_act", 1'b1, mon_act);
    chk1("sh_oe_n", 1'b0, sh_oe_n);
    chk1("sda_oe_n", 1'b1, sda_oe_n);
    foreach (rows[i])
    begin
      tst.set_mon(rows[i].pins);
      #1 chk1("sh_out", rows[i].out, sh_out);
    end
    for (int i = 0; i < 7; i++)
    begin
      v = 7'h7f << (i + 1);
      tst.set_mon(v);
      #1 chk1("sh_out", ~^v, sh_out);
    end
    tst.host_reset(1'b0, 1'b0);
    chk1("sio_act", 1'b1, sio_act);
    chkv("oe_n", '1, oe_n);
    chk1("ad0_oe_n", 1'b1, ad0_oe_n);
    chk1("tx", 1'b0, tx);
    e = 1'b0;
    for (int i = CW - 1; i >= 0; i--)
    begin
      tst.set_bit(i, 1'b1);
      e = ~e;
      #1 chk1("tx", e, tx);
    end
    // Host reset held low through the lowering walk
    @(negedge clk);
    tst.host_rst_n = 1'b0;
    repeat (3) @(negedge clk);
    chk1("tx", e, tx);
    for (int i = 0; i < CW; i++)
    begin
      tst.set_bit(i, 1'b0);
      e = ~e;
      #1 chk1("tx", e, tx);
    end
    chk1("sio_act", 1'b1, sio_act);
    chk1("sh_out", 1'b1, sh_out);
    tst.host_rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk1("sio_act", 1'b1, sio_act);
    tst.host_reset(1'b0, 1'b1);
    chk1("sio_act", 1'b0, sio_act);
    uart_norm = 1'b0;
    tst.set_bit(40, 1'b1);
    #1 chk1("tx", 1'b0, tx);
    chkv("oe_n", oe_norm, oe_n);
    tst.host_reset(1'b1, 1'b0);
    chk1("sio_act", 1'b0, sio_act);
    tst.mon_power(1'b0);
    chk1("mon_act", 1'b0, mon_act);
    chk1("sh_out", 1'b1, sh_out);
    tst.mon_power(1'b1);
    tst.host_reset(1'b0, 1'b0);
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    chk1("sio_act", 1'b0, sio_act);
    chk1("mon_act", 1'b0, mon_act);
    summarize();
  end
endmodule // board_xnor_chain_test_bench
